// file: include/cta_pkg.sv
// package of constants and carrier types for the console typewriter adapter
package cta_pkg;

  // register bus shape
  localparam int unsigned CTA_ADDR_W = 3;
  localparam int unsigned CTA_DATA_W = 8;

  // register indices on the plain register port
  localparam logic [2:0] CTA_OFS_FLAG  = 3'h0;
  localparam logic [2:0] CTA_OFS_CMD   = 3'h1;
  localparam logic [2:0] CTA_OFS_KEYB  = 3'h2;
  localparam logic [2:0] CTA_OFS_PRINT = 3'h3;
  localparam logic [2:0] CTA_OFS_TRAP  = 3'h4;

  // values after reset
  localparam logic [7:0] CTA_RST_BYTE = 8'h00;
  localparam logic [8:0] CTA_RST_WORD = 9'h100;

  // command register bits, bit 7 of the byte is the msb
  localparam int unsigned CTA_CMD_PROCEED_POS = 7;
  localparam int unsigned CTA_CMD_HOLDREQ_POS = 6;
  localparam int unsigned CTA_CMD_MUXREQ_POS  = 5;
  localparam int unsigned CTA_CMD_RESET_POS   = 4;
  localparam int unsigned CTA_CMD_ACK_POS     = 3;
  localparam int unsigned CTA_CMD_LEVREQ_POS  = 2;

  // status flag register bits
  localparam int unsigned CTA_FLG_ATTN_POS = 7;
  localparam int unsigned CTA_FLG_OPER_POS = 6;
  localparam int unsigned CTA_FLG_ALTD_POS = 5;
  localparam int unsigned CTA_FLG_BALL_POS = 3;
  localparam int unsigned CTA_FLG_END_POS  = 2;
  localparam int unsigned CTA_FLG_CREQ_POS = 1;
  localparam int unsigned CTA_FLG_CANC_POS = 0;

  // special print codes and trap block value
  localparam logic [7:0] CTA_PC_SHIFT   = 8'h01;
  localparam logic [7:0] CTA_PC_CR      = 8'h08;
  localparam logic [7:0] CTA_TRAP_BLOCK = 8'h0E;

  // pin synchroniser width, one bit per mechanism input
  localparam int unsigned CTA_SYNC_W = 14;

  // inputs from the typewriter mechanism and keyboard
  typedef struct packed {
    logic       ready;
    logic       request_key;
    logic       end_key;
    logic       cancel_key;
    logic       alter_key;
    logic       key_strobe;
    logic [7:0] key_code;
  } cta_mech_in_type;

  // outputs to the typewriter mechanism and lamps
  typedef struct packed {
    logic [7:0] print_code;
    logic       print_strobe;
    logic       carriage_return;
    logic       ball_side;
    logic       proceed_lamp;
    logic       request_pending_lamp;
  } cta_mech_out_type;

endpackage : cta_pkg

// file: hw/cta_pin_sync.sv
// two-stage synchroniser with rising-edge pulses for typewriter pins
`timescale 1ns/10ps
module cta_pin_sync #(
  parameter int unsigned WIDTH = 14
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // asynchronous pins in
  input  wire logic [WIDTH-1:0] pin_i,
  // synchronised levels and edges out
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
    end
  end

  // delayed copy for edge detection, taken from the settled stage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_reg <= '0;
    end else begin
      last_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~last_reg;

endmodule : cta_pin_sync

// file: hw/cta_adapter.sv
// console typewriter adapter: command, print, flag, keyboard and trap registers
//
// How it works
// RQ1 - four byte registers; host writes command and print code, reads flags, keyboard
// RQ2 - command write of zero clears its data bits, parity reads set
// RQ3 - print-code write of zero clears data bits, parity reads set
// RQ4 - reset-type command clears flags except ball side, which follows mechanism; operational follows ready and alter needs the 08 bit too
// RQ5 - zero command write leaves every sticky status flag unchanged
// RQ6 - typewriter becoming ready sets operational, end and console request
// RQ7 - host acknowledges with command 08; end and console request clear
// RQ8 - request key sets attention and console request, lights pending lamp
// RQ9 - command 08 clears attention, console request and pending lamp
// RQ10 - command 80 lights proceed lamp, flags untouched
// RQ11 - cancel key sets console request and cancel; command 08 clears both
// RQ12 - alter/display key sets its flag; command 84 clears it
// RQ13 - command 20 raises console request unless multiplexer hold-off set
// RQ14 - command 04 raises console request until zero command write
// RQ15 - command 40 sets sticky console request cleared only by command 10
// RQ16 - with command 50 loaded, print code 08 gives carriage return
// RQ17 - each print code 01 write shifts case, toggling ball-side flag
// RQ18 - print-code write prints that character on the mechanism; strobe goes out only with command 50 loaded
// RQ19 - with command 90 loaded, key presses load keyboard-code register
// RQ20 - host sets system byte bit 3 beforehand to reach remote typewriter
// RQ21 - trap register value 0E blocks trap requests to processor
// RQ22 - every stored register keeps an odd-parity bit generated on load; flags get theirs on read
// RQ23 - flags update on processor clock; system reset clears all registers
`timescale 1ns/10ps
module cta_adapter
  import cta_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // register port
  input  wire logic [CTA_ADDR_W-1:0] reg_addr_i,
  input  wire logic [CTA_DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [CTA_DATA_W:0]   reg_rdata_o,
  // processor side controls
  input  wire logic                  multiplexer_hold_off_i,
  output logic                       trap_req_o,
  // typewriter mechanism and keyboard
  input  wire cta_mech_in_type       mech_i,
  output cta_mech_out_type           mech_o
);

  // odd parity over a byte; an all-zero byte carries a set parity bit
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction : odd_par

  // address match used by the write decoder; reads use a case on the address
  function automatic logic hit(input logic [CTA_ADDR_W-1:0] a,
                               input logic [CTA_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ------------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------------
  logic [CTA_SYNC_W-1:0] pin_level;
  logic [CTA_SYNC_W-1:0] pin_rise;
  cta_mech_in_type       mech_sync;
  cta_mech_in_type       mech_edge;

  cta_pin_sync #(
    .WIDTH (CTA_SYNC_W)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (mech_i),
    .level_o (pin_level),
    .rise_o  (pin_rise)
  );

  assign mech_sync = cta_mech_in_type'(pin_level);
  assign mech_edge = cta_mech_in_type'(pin_rise);

  // the hold-off bit comes from another clocking area, so it is synchronised too
  logic hold_meta_reg;
  logic hold_sync_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_meta_reg <= 1'b0;
      hold_sync_reg <= 1'b0;
    end else begin
      hold_meta_reg <= multiplexer_hold_off_i;
      hold_sync_reg <= hold_meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  logic wr_cmd;
  logic wr_print;
  logic wr_trap;
  logic ack_cmd;
  logic reset_cmd;
  logic alter_clr_cmd;

  // only command, print and trap registers accept writes; the rest ignore them
  assign wr_cmd   = reg_wr_i & hit(reg_addr_i, CTA_OFS_CMD);   // RQ1
  assign wr_print = reg_wr_i & hit(reg_addr_i, CTA_OFS_PRINT); // RQ1
  assign wr_trap  = reg_wr_i & hit(reg_addr_i, CTA_OFS_TRAP);

  // command bit meanings, decoded from the byte being written
  assign ack_cmd       = wr_cmd & reg_wdata_i[CTA_CMD_ACK_POS];
  assign reset_cmd     = wr_cmd & reg_wdata_i[CTA_CMD_RESET_POS];
  assign alter_clr_cmd = wr_cmd & reg_wdata_i[CTA_CMD_PROCEED_POS]
                                & reg_wdata_i[CTA_CMD_LEVREQ_POS];

  // ------------------------------------------------------------------
  // command register with stored parity
  // ------------------------------------------------------------------
  logic [8:0] command_reg;
  logic [8:0] command_next;

  // a zero write gives all data bits clear and parity set
  always_comb begin
    command_next = command_reg;
    if (wr_cmd) begin
      command_next = {odd_par(reg_wdata_i), reg_wdata_i}; // RQ2 RQ22
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      command_reg <= CTA_RST_WORD; // RQ23
    end else begin
      command_reg <= command_next;
    end
  end

  // modes held in the command register
  logic print_allow;
  logic kbd_allow;

  assign print_allow = command_reg[CTA_CMD_HOLDREQ_POS] & command_reg[CTA_CMD_RESET_POS]; // RQ16
  assign kbd_allow   = command_reg[CTA_CMD_PROCEED_POS] & command_reg[CTA_CMD_RESET_POS]; // RQ19

  // ------------------------------------------------------------------
  // print-code register and mechanism strobes
  // ------------------------------------------------------------------
  logic [8:0] print_code_reg;
  logic       print_strobe_reg;
  logic       cr_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      print_code_reg <= CTA_RST_WORD;
    end else if (wr_print) begin
      print_code_reg <= {odd_par(reg_wdata_i), reg_wdata_i}; // RQ3 RQ22
    end
  end

  // one-cycle strobe to the mechanism; held off unless printing is allowed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      print_strobe_reg <= 1'b0;
      cr_reg           <= 1'b0;
    end else begin
      print_strobe_reg <= wr_print & print_allow;                                // RQ18
      cr_reg           <= wr_print & print_allow & (reg_wdata_i == CTA_PC_CR);   // RQ16
    end
  end

  // ------------------------------------------------------------------
  // ball side: toggled by every shift code, kept across command resets
  // ------------------------------------------------------------------
  logic ball_reg;

  // the mechanism shifts on its own code, so no command gate is applied here
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ball_reg <= 1'b0;
    end else if (wr_print && reg_wdata_i == CTA_PC_SHIFT) begin
      ball_reg <= ~ball_reg; // RQ17
    end
  end

  // ------------------------------------------------------------------
  // sticky status flags; a set in the same cycle as a clear wins
  // ------------------------------------------------------------------
  logic attn_reg;
  logic end_reg;
  logic cancel_reg;
  logic alter_reg;
  logic evreq_reg;
  logic holdreq_reg;
  logic pending_reg;

  // attention from the request key, cleared by acknowledge or reset command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      attn_reg <= 1'b0;
    end else begin
      attn_reg <= (attn_reg & ~ack_cmd & ~reset_cmd) | mech_edge.request_key; // RQ8 RQ9
    end
  end

  // end from ready coming up or from the end key
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      end_reg <= 1'b0;
    end else begin
      end_reg <= (end_reg & ~ack_cmd & ~reset_cmd)
               | mech_edge.ready | mech_edge.end_key; // RQ6 RQ7
    end
  end

  // cancel key
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cancel_reg <= 1'b0;
    end else begin
      cancel_reg <= (cancel_reg & ~ack_cmd & ~reset_cmd) | mech_edge.cancel_key; // RQ11
    end
  end

  // alter/display key, cleared by command 84 or a reset-type acknowledge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alter_reg <= 1'b0;
    end else begin
      alter_reg <= (alter_reg & ~alter_clr_cmd & ~(reset_cmd & ack_cmd))
                 | mech_edge.alter_key; // RQ12 RQ4
    end
  end

  // console request raised by typewriter events
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evreq_reg <= 1'b0;
    end else begin
      evreq_reg <= (evreq_reg & ~ack_cmd & ~reset_cmd)
                 | mech_edge.ready | mech_edge.request_key  // RQ6 RQ8
                 | mech_edge.end_key | mech_edge.cancel_key; // RQ11
    end
  end

  // command 40 request survives a zero write, only a command carrying the 10 reset bit drops it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      holdreq_reg <= 1'b0;
    end else begin
      holdreq_reg <= (holdreq_reg & ~reset_cmd)
                   | (wr_cmd & reg_wdata_i[CTA_CMD_HOLDREQ_POS]); // RQ15
    end
  end

  // request-pending lamp follows the request key until acknowledged
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= (pending_reg & ~ack_cmd & ~reset_cmd) | mech_edge.request_key; // RQ8 RQ9
    end
  end

  // ------------------------------------------------------------------
  // flag byte; level-type requests follow the command register directly
  // ------------------------------------------------------------------
  logic       creq;
  logic [7:0] flag_byte;

  // command 20 is gated by hold-off; 04 holds while loaded; zero drops both
  assign creq = evreq_reg | holdreq_reg
              | (command_reg[CTA_CMD_MUXREQ_POS] & ~hold_sync_reg) // RQ13
              | command_reg[CTA_CMD_LEVREQ_POS];                   // RQ14

  // a zero command write touches none of the sticky terms above
  always_comb begin
    flag_byte                   = CTA_RST_BYTE; // RQ5
    flag_byte[CTA_FLG_ATTN_POS] = attn_reg;
    flag_byte[CTA_FLG_OPER_POS] = mech_sync.ready;  // RQ6
    flag_byte[CTA_FLG_ALTD_POS] = alter_reg;
    flag_byte[CTA_FLG_BALL_POS] = ball_reg;         // RQ4
    flag_byte[CTA_FLG_END_POS]  = end_reg;
    flag_byte[CTA_FLG_CREQ_POS] = creq;
    flag_byte[CTA_FLG_CANC_POS] = cancel_reg;
  end

  // ------------------------------------------------------------------
  // keyboard-code register
  // ------------------------------------------------------------------
  logic [8:0] keyboard_code_reg;

  // code pins are settled by the time the strobe edge has passed the synchroniser
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      keyboard_code_reg <= CTA_RST_WORD;
    end else if (kbd_allow && mech_edge.key_strobe) begin
      keyboard_code_reg <= {odd_par(mech_sync.key_code), mech_sync.key_code}; // RQ19 RQ22
    end
  end

  // ------------------------------------------------------------------
  // trap-request register
  // ------------------------------------------------------------------
  logic [8:0] trap_ctl_reg;
  logic       trap_req_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trap_ctl_reg <= CTA_RST_WORD;
    end else if (wr_trap) begin
      trap_ctl_reg <= {odd_par(reg_wdata_i), reg_wdata_i}; // RQ22
    end
  end

  // registered so the processor sees a clean level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trap_req_reg <= 1'b0;
    end else begin
      trap_req_reg <= creq & (trap_ctl_reg[7:0] != CTA_TRAP_BLOCK); // RQ21
    end
  end

  // ------------------------------------------------------------------
  // read port: data in the cycle after the strobe, zero elsewhere
  // ------------------------------------------------------------------
  logic [8:0] rdata_reg;
  logic [8:0] rdata_next;

  // the flag byte gets parity on the fly since it is never written
  always_comb begin
    rdata_next = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        CTA_OFS_FLAG:  rdata_next = {odd_par(flag_byte), flag_byte}; // RQ1
        CTA_OFS_CMD:   rdata_next = command_reg;
        CTA_OFS_KEYB:  rdata_next = keyboard_code_reg;             // RQ1
        CTA_OFS_PRINT: rdata_next = print_code_reg;
        CTA_OFS_TRAP:  rdata_next = trap_ctl_reg;
        default:       rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reg_rdata_o                 = rdata_reg;
  assign trap_req_o                  = trap_req_reg;
  assign mech_o.print_code           = print_code_reg[7:0];
  assign mech_o.print_strobe         = print_strobe_reg;
  assign mech_o.carriage_return      = cr_reg;
  assign mech_o.ball_side            = ball_reg;
  assign mech_o.proceed_lamp         = command_reg[CTA_CMD_PROCEED_POS]; // RQ10
  assign mech_o.request_pending_lamp = pending_reg;

endmodule : cta_adapter

// file: verif/cta_adapter_monitor.sv
// port checker for the console typewriter adapter, bound to the adapter
`timescale 1ns/10ps
module cta_adapter_monitor
  import cta_pkg::*;
(
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_b_i,
  // register port
  input wire logic [CTA_ADDR_W-1:0] reg_addr_i,
  input wire logic [CTA_DATA_W-1:0] reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [CTA_DATA_W:0]   reg_rdata_o,
  // processor side
  input wire logic                  multiplexer_hold_off_i,
  input wire logic                  trap_req_o,
  // typewriter side
  input wire cta_mech_in_type       mech_i,
  input wire cta_mech_out_type      mech_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // write strobes per register
  wire logic cmd_wr = reg_wr_i && reg_addr_i == CTA_OFS_CMD;
  wire logic prt_wr = reg_wr_i && reg_addr_i == CTA_OFS_PRINT;
  wire logic trp_wr = reg_wr_i && reg_addr_i == CTA_OFS_TRAP;

  // block value written, then trap control left alone two cycles
  sequence s_block;
    trp_wr && reg_wdata_i == CTA_TRAP_BLOCK;
  endsequence
  sequence s_left;
    !trp_wr [*2];
  endsequence

  a_trap_blocked: assert property (s_block ##1 s_left |-> !trap_req_o)
    else $error("trap request while blocked");
  a_read_parity: assert property (reg_rd_i && reg_addr_i <= CTA_OFS_TRAP |=> ^reg_rdata_o)
    else $error("read data parity not odd");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > CTA_OFS_TRAP |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  a_proceed_lamp: assert property (cmd_wr |=> mech_o.proceed_lamp == $past(reg_wdata_i[7]))
    else $error("proceed lamp does not follow command");
  a_proceed_hold: assert property (!cmd_wr |=> $stable(mech_o.proceed_lamp))
    else $error("proceed lamp moved without command");
  a_print_code: assert property (prt_wr |=> mech_o.print_code == $past(reg_wdata_i))
    else $error("print code not taken");
  a_strobe_cause: assert property (mech_o.print_strobe |-> $past(prt_wr))
    else $error("print strobe without write");
  a_return_cause: assert property (mech_o.carriage_return |->
    $past(prt_wr && reg_wdata_i == CTA_PC_CR))
    else $error("carriage return without its code");
  a_ball_toggle: assert property (prt_wr && reg_wdata_i == CTA_PC_SHIFT |=>
    mech_o.ball_side != $past(mech_o.ball_side))
    else $error("ball side did not toggle");
endmodule : cta_adapter_monitor

bind cta_adapter cta_adapter_monitor mon_u (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .multiplexer_hold_off_i(multiplexer_hold_off_i),
  .trap_req_o(trap_req_o), .mech_i(mech_i), .mech_o(mech_o)
);

// file: verif/cta_typewriter_model.sv
// behavioural typewriter mechanism and keyboard facing the adapter
`timescale 1ns/10ps
module cta_typewriter_model
  import cta_pkg::*;
(
  // clock
  input  wire logic             clk_i,
  // mechanism ready level from the bench
  input  wire logic             ready_i,
  // adapter outputs seen by the mechanism
  input  wire cta_mech_out_type watch_i,
  // pins back to the adapter
  output cta_mech_in_type       drive_o
);
  logic [4:0] keys_reg  = 5'h00;
  logic [7:0] code_reg  = 8'hA5;
  logic [7:0] last_char = 8'h00;
  int         cr_cnt    = 0;

  // key order: request, end, cancel, alter, key strobe
  assign drive_o = {ready_i, keys_reg, code_reg};

  // contact held long enough for the pin synchroniser
  task automatic press(input int k, input logic [7:0] c);
    @(posedge clk_i);
    keys_reg[k] <= 1'b1;
    code_reg <= c;
    repeat (4) @(posedge clk_i);
    keys_reg[k] <= 1'b0;
    repeat (2) @(posedge clk_i);
    code_reg <= ~c; // stale code lines, never the last value
  endtask : press

  // mechanism counts returns and keeps the last printed code
  always @(posedge clk_i) begin
    if (watch_i.carriage_return) cr_cnt <= cr_cnt + 1;
    if (watch_i.print_strobe) last_char <= watch_i.print_code;
  end
endmodule : cta_typewriter_model

// file: verif/cta_adapter_tb.sv
// self-checking bench for the console typewriter adapter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module cta_adapter_tb;
  import cta_pkg::*;
  logic                  clk_i       = 1'b0;
  logic                  rst_b_i     = 1'b0;
  logic [CTA_ADDR_W-1:0] reg_addr_i  = '0;
  logic [CTA_DATA_W-1:0] reg_wdata_i = '0;
  logic                  reg_wr_i    = 1'b0;
  logic                  reg_rd_i    = 1'b0;
  logic                  hold_off    = 1'b0;
  logic                  ready       = 1'b0;
  logic [CTA_DATA_W:0]   reg_rdata_o;
  logic                  trap_req_o;
  cta_mech_in_type       mech_i;
  cta_mech_out_type      mech_o;
  int                    error_cnt   = 0;
  int                    checks_done = 0;
  int                    n0;
  logic [7:0]            ball        = 8'h00;
  logic [7:0]            v;
  logic [7:0]            kexp [3]    = '{8'h82, 8'h06, 8'h03};

  always #2 clk_i = ~clk_i;

  cta_adapter dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .multiplexer_hold_off_i(hold_off),
    .trap_req_o(trap_req_o), .mech_i(mech_i), .mech_o(mech_o));
  // only the local typewriter is attached, so the host's remote-select bit stays clear
  cta_typewriter_model tw_u (.clk_i(clk_i), .ready_i(ready), .watch_i(mech_o),
    .drive_o(mech_i));

  // stored byte with its odd parity bit
  function automatic logic [8:0] par9(input logic [7:0] b);
    return {~^b, b};
  endfunction : par9

  // bus tasks end just past the edge, so outputs have settled
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [8:0] e, input string nm);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(nm, e, reg_rdata_o)
  endtask : rd

  task automatic fl(input logic [7:0] e);
    rd(CTA_OFS_FLAG, par9(e), "flag");
  endtask : fl

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end

  // main sequence
  initial begin
    void'($urandom(32'h61E46BD4));
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int a = 1; a < 5; a++) rd(3'(a), 9'h100, "reset");
    for (int a = 5; a < 8; a++) rd(3'(a), 9'h000, "unmapped");
    wr(CTA_OFS_KEYB, 8'h5A);
    wr(CTA_OFS_FLAG, 8'hFF);
    rd(CTA_OFS_KEYB, 9'h100, "keyb ro");
    fl(8'h00);
    // random command and print bytes read back with parity
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      wr(CTA_OFS_CMD, v);
      rd(CTA_OFS_CMD, par9(v), "cmd");
    end
    wr(CTA_OFS_CMD, 8'h18);
    fl(ball);
    wr(CTA_OFS_CMD, 8'h00);
    rd(CTA_OFS_CMD, 9'h100, "cmd zero");
    fl(ball);
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? CTA_PC_SHIFT : 8'($urandom);
      wr(CTA_OFS_PRINT, v);
      if (v == CTA_PC_SHIFT) ball ^= 8'h08;
      rd(CTA_OFS_PRINT, par9(v), "print");
    end
    wr(CTA_OFS_PRINT, 8'h00);
    rd(CTA_OFS_PRINT, 9'h100, "print zero");
    @(posedge clk_i);
    ready <= 1'b1;
    idle(8);
    fl(8'h46 | ball);
    wr(CTA_OFS_CMD, 8'h08);
    fl(8'h40 | ball);
    // request, end and cancel keys, each acknowledged
    for (int k = 0; k < 3; k++) begin
      tw_u.press(4 - k, 8'h00);
      idle(4);
      fl(8'h40 | ball | kexp[k]);
      `CHK("lamp", k == 0, mech_o.request_pending_lamp)
      wr(CTA_OFS_CMD, 8'h08);
      fl(8'h40 | ball);
      `CHK("lamp off", 1'b0, mech_o.request_pending_lamp)
    end
    wr(CTA_OFS_CMD, 8'h80);
    `CHK("proceed", 1'b1, mech_o.proceed_lamp)
    fl(8'h40 | ball);
    tw_u.press(1, 8'h00);
    idle(4);
    fl(8'h60 | ball);
    wr(CTA_OFS_CMD, 8'h84);
    fl(8'h42 | ball);
    wr(CTA_OFS_CMD, 8'h00);
    fl(8'h40 | ball);
    wr(CTA_OFS_CMD, 8'h20);
    fl(8'h42 | ball);
    @(posedge clk_i);
    hold_off <= 1'b1;
    idle(4);
    fl(8'h40 | ball);
    @(posedge clk_i);
    hold_off <= 1'b0;
    idle(4);
    fl(8'h42 | ball);
    wr(CTA_OFS_CMD, 8'h00);
    fl(8'h40 | ball);
    // trap request follows console request until blocked
    wr(CTA_OFS_CMD, 8'h04);
    idle(2);
    `CHK("trap", 1'b1, trap_req_o)
    wr(CTA_OFS_TRAP, CTA_TRAP_BLOCK);
    idle(2);
    `CHK("trap off", 1'b0, trap_req_o)
    rd(CTA_OFS_TRAP, par9(CTA_TRAP_BLOCK), "trap reg");
    wr(CTA_OFS_CMD, 8'h40);
    wr(CTA_OFS_CMD, 8'h00);
    fl(8'h42 | ball);
    wr(CTA_OFS_CMD, 8'h10);
    fl(8'h40 | ball);
    for (int i = 0; i < 2; i++) begin
      wr(CTA_OFS_PRINT, CTA_PC_SHIFT);
      ball ^= 8'h08;
      fl(8'h40 | ball);
    end
    // printing with command 50 loaded
    wr(CTA_OFS_CMD, 8'h50);
    n0 = tw_u.cr_cnt;
    wr(CTA_OFS_PRINT, CTA_PC_CR);
    idle(2);
    `CHK("return", n0 + 1, tw_u.cr_cnt)
    wr(CTA_OFS_PRINT, 8'h02);
    idle(2);
    `CHK("printed", 8'h02, tw_u.last_char)
    // keyboard capture with command 90 loaded
    wr(CTA_OFS_CMD, 8'h90);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      tw_u.press(0, v);
      idle(4);
      rd(CTA_OFS_KEYB, par9(v), "keyb");
    end
    close_out();
  end
endmodule : cta_adapter_tb
